// ---- core/pps_pkg.sv ----
// Package with the constants and state types of the pulse output block.
package pps_pkg;

	// -----------------------------------------------------------------
	// Clocking and reference
	// -----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned REF_HZ = 10_000_000;
	localparam int unsigned PRESCALE = CLK_HZ / REF_HZ;
	localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE - 1);
	localparam logic [63:0] REF_NUM = 64'(REF_HZ);

	// -----------------------------------------------------------------
	// Duty scale and divider
	// -----------------------------------------------------------------
	localparam logic [31:0] DUTY_FULL = 32'h0000_7d00;
	localparam logic [31:0] DUTY_HALF = 32'h0000_3e80;
	localparam logic [6:0] DIV_STEPS = 7'h40;

	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DUTY = 8'h04;
	localparam logic [7:0] OFF_FREQ = 8'h08;
	localparam logic [7:0] OFF_RUNF = 8'h0c;
	localparam logic [7:0] OFF_ACCC = 8'h10;
	localparam logic [7:0] OFF_RUNC = 8'h14;
	localparam logic [7:0] OFF_DECC = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1c;
	localparam logic [7:0] OFF_ISTAT = 8'h20;
	localparam logic [7:0] OFF_IMASK = 8'h24;

	// -----------------------------------------------------------------
	// Field positions and reset values
	// -----------------------------------------------------------------
	localparam int CTRL_MODE = 0;
	localparam int CTRL_START = 1;
	localparam int STAT_READY = 0;
	localparam int STAT_ERR = 1;
	localparam int STAT_BUSY = 2;
	localparam int STAT_PULSE = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [1:0] IMASK_RST = 2'h0;

	// -----------------------------------------------------------------
	// State types
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_NEXT = 4'b0010,
		ST_CALC = 4'b0100,
		ST_RUN = 4'b1000
	} pps_step_type;

	typedef enum logic [2:0] {
		PH_ACC = 3'b001,
		PH_RUN = 3'b010,
		PH_DEC = 3'b100
	} pps_phase_type;

	typedef enum logic [3:0] {
		CA_IDLE = 4'b0001,
		CA_LIN = 4'b0010,
		CA_PER = 4'b0100,
		CA_HI = 4'b1000
	} pps_calc_type;

endpackage

// ---- core/pps_top.sv ----
// Pulse output channel: PWM or stepper pulse train behind an AHB-Lite slave.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
module pps_top (
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic O_PULSE,
	output logic O_READY,
	output logic O_ERROR,
	output logic O_IRQ
);

	// -----------------------------------------------------------------
	// Bus slave
	// -----------------------------------------------------------------
	logic wr_pend_q, rd_pend_q, hready_q, hresp_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q, rd_mux;
	logic [1:0] ctrl_q, imask_q, istat_q, ev;
	logic [31:0] duty_q, freq_q, runf_q, accc_q, runc_q, decc_q;
	logic ready_q, err_q, pulse_q, irq_q;
	pps_pkg::pps_step_type st_q;

	wire logic addr_ok = I_HSEL & I_HTRANS[1] & I_HREADY;
	wire logic we_ctrl = wr_pend_q && addr_q == pps_pkg::OFF_CTRL;
	wire logic we_duty = wr_pend_q && addr_q == pps_pkg::OFF_DUTY;
	wire logic we_freq = wr_pend_q && addr_q == pps_pkg::OFF_FREQ;
	wire logic we_runf = wr_pend_q && addr_q == pps_pkg::OFF_RUNF;
	wire logic we_accc = wr_pend_q && addr_q == pps_pkg::OFF_ACCC;
	wire logic we_runc = wr_pend_q && addr_q == pps_pkg::OFF_RUNC;
	wire logic we_decc = wr_pend_q && addr_q == pps_pkg::OFF_DECC;
	wire logic we_istat = wr_pend_q && addr_q == pps_pkg::OFF_ISTAT;
	wire logic we_imask = wr_pend_q && addr_q == pps_pkg::OFF_IMASK;
	wire logic st_busy = st_q != pps_pkg::ST_IDLE;
	wire logic [31:0] stat_word = {28'h0, pulse_q, st_busy, err_q, ready_q};

	assign rd_mux =
		addr_q == pps_pkg::OFF_CTRL ? {30'h0, ctrl_q} :
		addr_q == pps_pkg::OFF_DUTY ? duty_q :
		addr_q == pps_pkg::OFF_FREQ ? freq_q :
		addr_q == pps_pkg::OFF_RUNF ? runf_q :
		addr_q == pps_pkg::OFF_ACCC ? accc_q :
		addr_q == pps_pkg::OFF_RUNC ? runc_q :
		addr_q == pps_pkg::OFF_DECC ? decc_q :
		addr_q == pps_pkg::OFF_STAT ? stat_word :
		addr_q == pps_pkg::OFF_ISTAT ? {30'h0, istat_q} :
		addr_q == pps_pkg::OFF_IMASK ? {30'h0, imask_q} : 32'h0;

	// Reads take one wait state so a write just before is always visible.
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h0;
		end else begin
			wr_pend_q <= addr_ok & I_HWRITE;
			rd_pend_q <= addr_ok & ~I_HWRITE;
			if (addr_ok)
				addr_q <= I_HADDR[7:0];
			hready_q <= ~(addr_ok & ~I_HWRITE);
			if (rd_pend_q)
				hrdata_q <= rd_mux;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ctrl_q <= pps_pkg::CTRL_RST;
			imask_q <= pps_pkg::IMASK_RST;
			duty_q <= 32'h0;
			freq_q <= 32'h0;
			runf_q <= 32'h0;
			accc_q <= 32'h0;
			runc_q <= 32'h0;
			decc_q <= 32'h0;
		end else begin
			if (we_ctrl)
				ctrl_q <= I_HWDATA[1:0];
			if (we_imask)
				imask_q <= I_HWDATA[1:0];
			if (we_duty)
				duty_q <= I_HWDATA;
			if (we_freq)
				freq_q <= I_HWDATA;
			if (we_runf)
				runf_q <= I_HWDATA;
			if (we_accc)
				accc_q <= I_HWDATA;
			if (we_runc)
				runc_q <= I_HWDATA;
			if (we_decc)
				decc_q <= I_HWDATA;
		end
	end

	// A new event wins over a write-one-to-clear in the same cycle.
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			istat_q <= 2'h0;
			irq_q <= 1'b0;
		end else begin
			istat_q <= (istat_q & ~(we_istat ? I_HWDATA[1:0] : 2'h0)) | ev;
			irq_q <= |(istat_q & imask_q);
		end
	end

	// -----------------------------------------------------------------
	// Reference tick and shared divider
	// -----------------------------------------------------------------
	logic [3:0] pre_q;
	logic [63:0] dvd_q, div_num;
	logic [32:0] rem_q;
	logic [31:0] den_q, div_den;
	logic [6:0] dcnt_q;
	logic div_go, div_done_q;

	wire logic ref_tick = pre_q == pps_pkg::PRESCALE_LAST;
	wire logic [32:0] rem_sh = {rem_q[31:0], dvd_q[63]};
	wire logic rem_ge = rem_sh >= {1'b0, den_q};
	wire logic [32:0] rem_nx = rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;
	wire logic [31:0] quot = |dvd_q[63:32] ? 32'hffff_ffff : dvd_q[31:0];
	wire logic [31:0] per_new = quot == 32'h0 ? 32'h1 : quot;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST)
			pre_q <= 4'h0;
		else
			pre_q <= ref_tick ? 4'h0 : pre_q + 4'h1;
	end

	// Restoring divider, one quotient bit per clock, shared by all users.
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			dvd_q <= 64'h0;
			rem_q <= 33'h0;
			den_q <= 32'h0;
			dcnt_q <= 7'h0;
			div_done_q <= 1'b0;
		end else begin
			div_done_q <= dcnt_q == 7'h1;
			if (div_go) begin
				dvd_q <= div_num;
				den_q <= div_den;
				rem_q <= 33'h0;
				dcnt_q <= pps_pkg::DIV_STEPS;
			end else if (dcnt_q != 7'h0) begin
				dvd_q <= {dvd_q[62:0], rem_ge};
				rem_q <= rem_nx;
				dcnt_q <= dcnt_q - 7'h1;
			end
		end
	end

	// -----------------------------------------------------------------
	// Period calculation
	// -----------------------------------------------------------------
	pps_pkg::pps_calc_type ca_q, ca_d;
	pps_pkg::pps_phase_type ph_q;
	logic [31:0] f_q, f_d, per_q, hi_q, k_q;
	logic [31:0] lat_start_q, lat_run_q, lat_acc_q, lat_runc_q, lat_dec_q;
	logic ca_pwm_q, pwm_d, per_ld, hi_ld, done_q, done_d, go_per;
	logic pwm_dirty_q;

	wire logic [31:0] ph_cnt = ph_q == pps_pkg::PH_ACC ? lat_acc_q :
		ph_q == pps_pkg::PH_RUN ? lat_runc_q : lat_dec_q;
	wire logic st_req = st_q == pps_pkg::ST_NEXT && k_q != ph_cnt;
	wire logic [31:0] span = lat_run_q - lat_start_q;
	wire logic pwm_req = pwm_dirty_q && !st_busy && !ctrl_q[0] &&
		ca_q == pps_pkg::CA_IDLE;

	always_comb begin
		ca_d = ca_q;
		f_d = f_q;
		pwm_d = ca_pwm_q;
		div_go = 1'b0;
		div_num = 64'h0;
		div_den = 32'h0;
		per_ld = 1'b0;
		hi_ld = 1'b0;
		done_d = 1'b0;
		go_per = 1'b0;
		case (ca_q)
			pps_pkg::CA_IDLE: begin
				if (st_req && ph_q == pps_pkg::PH_RUN) begin
					pwm_d = 1'b0;
					f_d = lat_run_q;
					go_per = 1'b1;
					ca_d = pps_pkg::CA_PER;
				end else if (st_req) begin
					pwm_d = 1'b0;
					div_go = 1'b1;
					div_num = 64'(span) * 64'(k_q);
					div_den = ph_cnt - 32'h1;
					ca_d = pps_pkg::CA_LIN;
				end else if (pwm_req) begin
					pwm_d = 1'b1;
					f_d = freq_q;
					go_per = 1'b1;
					ca_d = pps_pkg::CA_PER;
				end
			end
			pps_pkg::CA_LIN: begin
				if (div_done_q) begin
					f_d = ph_q == pps_pkg::PH_ACC ? lat_start_q + quot :
						lat_run_q - quot;
					go_per = 1'b1;
					ca_d = pps_pkg::CA_PER;
				end
			end
			pps_pkg::CA_PER: begin
				if (div_done_q) begin
					per_ld = 1'b1;
					if (ca_pwm_q) begin
						div_go = 1'b1;
						div_num = 64'(per_new) * 64'(duty_q) +
							64'(pps_pkg::DUTY_HALF);
						div_den = pps_pkg::DUTY_FULL;
						ca_d = pps_pkg::CA_HI;
					end else begin
						done_d = 1'b1;
						ca_d = pps_pkg::CA_IDLE;
					end
				end
			end
			pps_pkg::CA_HI: begin
				if (div_done_q) begin
					hi_ld = 1'b1;
					done_d = 1'b1;
					ca_d = pps_pkg::CA_IDLE;
				end
			end
			default: ca_d = pps_pkg::CA_IDLE;
		endcase
		if (go_per) begin
			div_go = 1'b1;
			div_num = pps_pkg::REF_NUM + 64'(f_d[31:1]);
			div_den = f_d;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ca_q <= pps_pkg::CA_IDLE;
			ca_pwm_q <= 1'b0;
			f_q <= 32'h0;
			per_q <= 32'h1;
			hi_q <= 32'h0;
			done_q <= 1'b0;
		end else begin
			ca_q <= ca_d;
			ca_pwm_q <= pwm_d;
			f_q <= f_d;
			done_q <= done_d;
			if (per_ld)
				per_q <= per_new;
			if (hi_ld)
				hi_q <= quot;
		end
	end

	// -----------------------------------------------------------------
	// Stepper sequencer
	// -----------------------------------------------------------------
	// The step period is recomputed between steps, so each step carries
	// a short extra low time; it matters only near the top frequencies.
	logic start_prev_q, armed_q;
	logic [31:0] tcnt_q, pcnt_q;

	wire logic mode_step = ctrl_q[pps_pkg::CTRL_MODE];
	wire logic start_bit = ctrl_q[pps_pkg::CTRL_START];
	wire logic start_rise = start_bit & ~start_prev_q;
	wire logic ramp_used = accc_q != 32'h0 || decc_q != 32'h0;
	wire logic start_ok = accc_q != 32'h1 && decc_q != 32'h1 &&
		runf_q != 32'h0 && !(ramp_used &&
		(freq_q == 32'h0 || freq_q > runf_q));
	wire logic go_idle = st_q == pps_pkg::ST_IDLE && start_rise && mode_step;
	wire logic abort = st_busy && !(start_bit && mode_step);
	wire logic step_end = st_q == pps_pkg::ST_RUN && ref_tick &&
		tcnt_q == per_q - 32'h1;
	wire logic move_end = st_q == pps_pkg::ST_NEXT && !abort &&
		k_q == ph_cnt && ph_q == pps_pkg::PH_DEC;
	wire logic step_level = tcnt_q < {1'b0, per_q[31:1]} || tcnt_q == 32'h0;

	assign ev = {(go_idle && !start_ok) || abort, move_end};

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			st_q <= pps_pkg::ST_IDLE;
			ph_q <= pps_pkg::PH_ACC;
			k_q <= 32'h0;
			tcnt_q <= 32'h0;
			ready_q <= 1'b1;
			err_q <= 1'b0;
			start_prev_q <= 1'b0;
			armed_q <= 1'b0;
			lat_start_q <= 32'h0;
			lat_run_q <= 32'h0;
			lat_acc_q <= 32'h0;
			lat_runc_q <= 32'h0;
			lat_dec_q <= 32'h0;
		end else begin
			start_prev_q <= start_bit;
			if (abort) begin
				st_q <= pps_pkg::ST_IDLE;
				ready_q <= 1'b1;
				err_q <= 1'b1;
				armed_q <= 1'b0;
			end else case (st_q)
				pps_pkg::ST_IDLE: begin
					if (go_idle && !start_ok)
						err_q <= 1'b1;
					else if (go_idle) begin
						lat_start_q <= freq_q;
						lat_run_q <= runf_q;
						lat_acc_q <= accc_q;
						lat_runc_q <= runc_q;
						lat_dec_q <= decc_q;
						err_q <= 1'b0;
						ready_q <= 1'b0;
						ph_q <= pps_pkg::PH_ACC;
						k_q <= 32'h0;
						st_q <= pps_pkg::ST_NEXT;
					end
				end
				pps_pkg::ST_NEXT: begin
					if (move_end) begin
						ready_q <= 1'b1;
						st_q <= pps_pkg::ST_IDLE;
					end else if (k_q == ph_cnt) begin
						ph_q <= ph_q == pps_pkg::PH_ACC ? pps_pkg::PH_RUN :
							pps_pkg::PH_DEC;
						k_q <= 32'h0;
					end else if (ca_q == pps_pkg::CA_IDLE)
						// A PWM update may still hold the shared divider.
						st_q <= pps_pkg::ST_CALC;
				end
				pps_pkg::ST_CALC: begin
					// Start on a tick so the first tick of a step is whole.
					if (done_q)
						armed_q <= 1'b1;
					if ((done_q || armed_q) && ref_tick) begin
						armed_q <= 1'b0;
						tcnt_q <= 32'h0;
						st_q <= pps_pkg::ST_RUN;
					end
				end
				pps_pkg::ST_RUN: begin
					if (step_end) begin
						k_q <= k_q + 32'h1;
						st_q <= pps_pkg::ST_NEXT;
					end else if (ref_tick)
						tcnt_q <= tcnt_q + 32'h1;
				end
				default: st_q <= pps_pkg::ST_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// PWM counter and output
	// -----------------------------------------------------------------
	// Full scale forces high, zero forces low.
	wire logic pwm_level = duty_q >= pps_pkg::DUTY_FULL ? 1'b1 :
		(duty_q == 32'h0 || freq_q == 32'h0) ? 1'b0 : pcnt_q < hi_q;
	wire logic pulse_d = mode_step ?
		(st_q == pps_pkg::ST_RUN && step_level) : pwm_level;
	wire logic dirty_set = we_duty || we_freq || we_ctrl || move_end;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pcnt_q <= 32'h0;
			pwm_dirty_q <= 1'b1;
			pulse_q <= 1'b0;
		end else begin
			if (ref_tick)
				pcnt_q <= pcnt_q >= per_q - 32'h1 ? 32'h0 : pcnt_q + 32'h1;
			pwm_dirty_q <= dirty_set || (pwm_dirty_q && !pwm_req);
			pulse_q <= pulse_d;
		end
	end

	assign O_HRDATA = hrdata_q;
	assign O_HREADYOUT = hready_q;
	assign O_HRESP = hresp_q;
	assign O_PULSE = pulse_q;
	assign O_READY = ready_q;
	assign O_ERROR = err_q;
	assign O_IRQ = irq_q;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);

	sequence s_go;
		go_idle && start_ok;
	endsequence

	chk_full_high: assert property (
		!mode_step && duty_q >= pps_pkg::DUTY_FULL |=> pulse_q)
		else $error("Full duty did not hold the output high.");
	chk_zero_low: assert property (
		!mode_step && duty_q == 32'h0 |=> !pulse_q)
		else $error("Zero duty did not hold the output low.");
	chk_high_scale: assert property (
		hi_ld && per_q == 32'd100 && duty_q == 32'd28800
		|=> hi_q == 32'd90)
		else $error("High time is not the scaled duty.");
	chk_freq_hertz: assert property (
		per_ld && ca_pwm_q && f_q == 32'd100000 |=> per_q == 32'd100)
		else $error("A hundred kilohertz did not give a hundred ticks.");
	chk_move_start: assert property (
		s_go |=> st_q == pps_pkg::ST_NEXT && ph_q == pps_pkg::PH_ACC &&
		k_q == 32'h0)
		else $error("Move did not begin at the first step.");
	chk_ready_busy: assert property (
		st_busy |-> !ready_q)
		else $error("Ready flag high during a move.");
	chk_ref_tick: assert property (
		ref_tick |=> (!ref_tick)[*8] ##1 !ref_tick ##1 ref_tick)
		else $error("Reference tick is not one in ten clocks.");
	chk_param_hold: assert property (
		st_busy && $past(st_busy) |-> $stable(lat_run_q) &&
		$stable(lat_acc_q) && $stable(lat_start_q))
		else $error("Latched parameter changed during a move.");
	chk_abort_err: assert property (
		st_busy && !start_bit |=> err_q && !st_busy && ready_q)
		else $error("Start loss did not abort with error.");
	chk_bad_accel: assert property (
		go_idle && accc_q == 32'h1 |=> err_q && !st_busy)
		else $error("Accel count of one was not rejected.");
	chk_err_clear: assert property (
		s_go |=> !err_q ##1 !ready_q || !st_busy)
		else $error("Error not cleared on a valid start.");

endmodule // pps_top

// ---- verification/pps_load_model.sv ----
// Behavioural load on the pulse output that measures pulse timing.
`timescale 1ns/100ps
module pps_load_model (
	input wire logic i_clk,
	input wire logic i_clear,
	input wire logic i_pulse,
	output int o_rises,
	output int o_first_high,
	output int o_last_high,
	output int o_period
);
	// -----------------------------------------------------------------
	// Edge timing
	// -----------------------------------------------------------------
	// A drive input only reacts to edges, so widths are kept in clocks.
	int high_cnt;
	int per_cnt;
	logic prev_q = 1'b0;
	always @(posedge i_clk) begin
		if (i_clear) begin
			o_rises <= 0;
			o_first_high <= 0;
			high_cnt <= 0;
			per_cnt <= 0;
		end else begin
			per_cnt <= per_cnt + 1;
			if (i_pulse)
				high_cnt <= high_cnt + 1;
			if (i_pulse && !prev_q) begin
				o_rises <= o_rises + 1;
				o_period <= per_cnt;
				per_cnt <= 1;
				high_cnt <= 1;
			end
			if (!i_pulse && prev_q) begin
				o_last_high <= high_cnt;
				if (o_first_high == 0)
					o_first_high <= high_cnt;
			end
		end
		prev_q <= i_pulse;
	end
endmodule // pps_load_model

// ---- verification/pps_top_tb_top.sv ----
// Self-checking testbench of the pulse output block.
`timescale 1ns/100ps
module pps_top_tb_top;
	// -----------------------------------------------------------------
	// Signals and instances
	// -----------------------------------------------------------------
	localparam int LIMIT = 90000;
	localparam logic [31:0] F_START = 32'h0001_86a0;
	localparam logic [31:0] F_RUN = 32'h0003_0d40;
	localparam logic [31:0] F_ODD = 32'h0000_7530;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic ld_clear = 1'b0;
	logic [31:0] rdata;
	logic hready;
	logic hresp;
	logic pulse;
	logic ready;
	logic error;
	logic irq;
	int rises;
	int first_high;
	int last_high;
	int period;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	pps_top uut (.I_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
		.O_HRDATA(rdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
		.O_PULSE(pulse), .O_READY(ready), .O_ERROR(error), .O_IRQ(irq));
	pps_load_model load (.i_clk(clk), .i_clear(ld_clear), .i_pulse(pulse),
		.o_rises(rises), .o_first_high(first_high),
		.o_last_high(last_high), .o_period(period));
	initial begin
		forever #5 clk = ~clk;
	end
	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	task automatic end_of_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = rdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic wcyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic clr;
		@(posedge clk);
		ld_clear <= 1'b1;
		@(posedge clk);
		ld_clear <= 1'b0;
	endtask
	// A move is waited for by its ready flag; the watchdog bounds it.
	task automatic move_done;
		while (ready !== 1'b0) @(posedge clk);
		while (ready !== 1'b1) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_mismatch++;
			end_of_test;
		end
	end
	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({28'h0, ready, error, irq, pulse}, 32'h8);
		rdc(pps_pkg::OFF_CTRL, 32'h0);
		rdc(pps_pkg::OFF_IMASK, 32'h0);
		rdc(pps_pkg::OFF_STAT, 32'h1);
		wr(pps_pkg::OFF_STAT, 32'hff);
		rdc(pps_pkg::OFF_STAT, 32'h1);
		wr(8'h28, 32'h5);
		rdc(8'h28, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		// PWM at 100 kHz and 90 percent duty.
		wr(pps_pkg::OFF_FREQ, F_START);
		wr(pps_pkg::OFF_DUTY, 32'h7080);
		wcyc(3000);
		clr;
		wcyc(2100);
		chk(period, 32'd1000);
		chk(last_high, 32'd900);
		// An uneven divisor must round to a whole reference count.
		wr(pps_pkg::OFF_FREQ, F_ODD);
		wr(pps_pkg::OFF_DUTY, 32'h1f40);
		wcyc(1000);
		clr;
		wcyc(7000);
		chk(period, 32'd3330);
		chk(last_high, 32'd830);
		wr(pps_pkg::OFF_DUTY, pps_pkg::DUTY_FULL);
		wcyc(200);
		clr;
		wcyc(4000);
		chk({31'h0, pulse}, 32'h1);
		chk(rises, 32'd0);
		wr(pps_pkg::OFF_DUTY, 32'h0);
		wcyc(200);
		clr;
		wcyc(4000);
		chk({31'h0, pulse}, 32'h0);
		chk(rises, 32'd0);
		// Stepper move of two, two and two steps.
		wr(pps_pkg::OFF_RUNF, F_RUN);
		wr(pps_pkg::OFF_FREQ, F_START);
		wr(pps_pkg::OFF_ACCC, 32'h2);
		wr(pps_pkg::OFF_RUNC, 32'h2);
		wr(pps_pkg::OFF_DECC, 32'h2);
		wr(pps_pkg::OFF_IMASK, 32'h3);
		wr(pps_pkg::OFF_CTRL, 32'h1);
		clr;
		rdc(pps_pkg::OFF_STAT, 32'h1);
		wr(pps_pkg::OFF_CTRL, 32'h3);
		wr(pps_pkg::OFF_RUNC, 32'h64);
		chk({31'h0, ready}, 32'h0);
		move_done;
		chk(rises, 32'd6);
		chk(first_high, 32'd500);
		chk(last_high, 32'd500);
		wcyc(2);
		chk({30'h0, error, irq}, 32'h1);
		rdc(pps_pkg::OFF_ISTAT, 32'h1);
		wr(pps_pkg::OFF_ISTAT, 32'h1);
		wcyc(2);
		chk({31'h0, irq}, 32'h0);
		// Acceleration count of one is refused.
		wr(pps_pkg::OFF_CTRL, 32'h1);
		wr(pps_pkg::OFF_ACCC, 32'h1);
		clr;
		wr(pps_pkg::OFF_CTRL, 32'h3);
		wcyc(200);
		chk({29'h0, ready, error, irq}, 32'h7);
		chk(rises, 32'd0);
		rdc(pps_pkg::OFF_ISTAT, 32'h2);
		// Corrected parameters clear the error; zero counts skip phases.
		wr(pps_pkg::OFF_ISTAT, 32'h3);
		wr(pps_pkg::OFF_ACCC, 32'h0);
		wr(pps_pkg::OFF_DECC, 32'h0);
		wr(pps_pkg::OFF_RUNC, 32'h3);
		wr(pps_pkg::OFF_CTRL, 32'h1);
		clr;
		wr(pps_pkg::OFF_CTRL, 32'h3);
		move_done;
		chk({31'h0, error}, 32'h0);
		chk(rises, 32'd3);
		chk(first_high, 32'd250);
		// Dropping start in mid-move aborts it.
		wr(pps_pkg::OFF_CTRL, 32'h1);
		wr(pps_pkg::OFF_RUNC, 32'h32);
		wr(pps_pkg::OFF_CTRL, 32'h3);
		wcyc(3000);
		wr(pps_pkg::OFF_CTRL, 32'h1);
		wcyc(200);
		chk({29'h0, ready, error, pulse}, 32'h6);
		wr(pps_pkg::OFF_IMASK, 32'h0);
		wcyc(2);
		chk({31'h0, irq}, 32'h0);
		wr(pps_pkg::OFF_IMASK, 32'h2);
		wcyc(2);
		chk({31'h0, irq}, 32'h1);
		end_of_test;
	end
endmodule // pps_top_tb_top
